// File: src/wdt_pkg.sv
package wdt_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CONTROL = 4'h8; // watchdog_control
    localparam logic [3:0] IDX_BYPASS = 4'h9; // factory_test_bypass
    localparam logic [3:0] IDX_TESTCTL = 4'hA; // factory_test_control
    localparam logic [3:0] IDX_SERVICE = 4'hB; // watchdog_service
    localparam logic [3:0] IDX_AUX = 4'hC; // pseudo-stop enable
    localparam logic [3:0] IDX_STATUS = 4'hD; // live watchdog state
    localparam int ADDR_W = 8; // bus address width
    // watchdog_control and aux register field positions
    localparam int CTL_WINDOW_BIT = 7; // window_mode_bit
    localparam int CTL_DEBUG_BIT = 6; // debug_halt_bit
    localparam int RATE_W = 3; // timeout_rate_select width
    localparam int AUX_PSE_BIT = 0; // pseudo_stop_watchdog_enable
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] BYPASS_RST = 8'h00;
    localparam logic [7:0] TESTCTL_RST = 8'h80; // also the user-mode read
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] SERVICE_READ = 8'h00;
    // service keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // log2 of the time-out for rate codes 7 down to 1, five bits each
    localparam int LOG2_W = 5;
    localparam logic [34:0] RATE_LOG2_DEFAULT =
        {5'h18, 5'h17, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0E};
    localparam int CNT_W = 25; // holds up to 2^24
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // true when a byte address hits one of the registers
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        return (addr[1:0] == 2'h0) && (addr[ADDR_W-1:6] == 2'h0) &&
            (idx >= IDX_CONTROL) && (idx <= IDX_STATUS);
    endfunction
endpackage

// File: src/wdt_axil_slave.sv
`timescale 1ns/1ps
// axi4-lite slave; turns bus traffic into one-cycle register strobes
module wdt_axil_slave
    import wdt_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [3:0] wr_idx,
    output logic [7:0] wr_data,
    output logic [3:0] rd_idx,
    input wire logic [7:0] rd_data
);
    logic aw_have_reg; // address held
    logic w_have_reg; // data held
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg; // low byte lane was strobed
    logic wr_fire; // both halves present, response slot free

    assign awready = !aw_have_reg;
    assign wready = !w_have_reg;
    assign arready = !rvalid;
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
    // unmapped or lane-less writes answer but touch nothing
    assign wr_en = wr_fire && addr_mapped(aw_addr_reg) && w_lane_reg;
    assign wr_idx = aw_addr_reg[5:2];
    assign wr_data = w_byte_reg;
    assign rd_idx = araddr[5:2];

    // address and data channels, taken in either order
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_reg <= 1'b1;
                w_byte_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // write response, one cycle after both halves meet
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read data registered at the address handshake
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= addr_mapped(araddr) ? {24'h00_0000, rd_data} : 32'h0;
            rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // wdt_axil_slave

// File: src/wdt_period_counter.sv
`timescale 1ns/1ps
// free counter measured against the selected time-out
module wdt_period_counter
    import wdt_pkg::*;
#(
    parameter logic [34:0] RATE_LOG2 = wdt_pkg::RATE_LOG2_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wdt_pkg::RATE_W-1:0] rate,
    input wire logic restart,
    input wire logic freeze,
    output logic expire,
    output logic early,
    output logic [wdt_pkg::CNT_W-1:0] count,
    output logic [wdt_pkg::CNT_W-1:0] period
);
    // cycles in one period for a nonzero rate code
    function automatic logic [CNT_W-1:0] period_of(input logic [2:0] r);
        logic [LOG2_W-1:0] lg;
        lg = RATE_LOG2[(r - 3'h1) * LOG2_W +: LOG2_W];
        return (r == 3'h0) ? '0 : ({{(CNT_W-1){1'b0}}, 1'b1} << lg);
    endfunction

    logic [CNT_W-1:0] cnt_reg;

    assign count = cnt_reg;
    assign period = period_of(rate);
    // fires on the last cycle of the period
    assign expire = (rate != 3'h0) && !freeze && !restart &&
        (cnt_reg == period - 1'b1);
    // first 75 percent of the period
    assign early = cnt_reg < (period - (period >> 2));

    // counts oscillator cycles; expiry restarts from zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (restart || expire || rate == 3'h0) begin
            cnt_reg <= '0;
        end else if (!freeze) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule // wdt_period_counter

// File: src/wdt_watchdog.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - window and rate bits write once, special anytime
// - debug-halt freezes counters in background debug
// - rate code picks time-out length, zero disables
// - nonzero rate write enables and restarts period
// - counter reaching time-out requests system reset
// - first then second key restarts the counter
// - any other service value resets immediately
// - repeated identical keys are harmless
// - service writes ignored while watchdog disabled
// - service register writable anytime, reads zero
// - window mode faults writes in first 75%
// - window accepts many first keys; pair restarts
// - period counts from latest restart or reset
// - bypass test register zero, writable in special
// - test control reads 0x80, writable in special
// - pseudo-stop without enable holds the count
module wdt_watchdog
    import wdt_pkg::*;
#(
    parameter logic [34:0] RATE_LOG2 = wdt_pkg::RATE_LOG2_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic special_mode,
    input wire logic debug_active,
    input wire logic pseudo_stop_active,
    output logic reset_request,
    output logic periodic_timer_freeze
);
    import wdt_pkg::*;

    // bus strobes
    logic wr_en;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [3:0] rd_idx;
    logic [7:0] rd_data;
    // control state
    logic window_reg; // window_mode_bit
    logic debug_halt_reg; // debug_halt_bit
    logic [RATE_W-1:0] rate_reg; // timeout_rate_select
    logic ctl_locked_reg; // window/rate already written once
    logic dbg_locked_reg; // debug-halt already written once
    logic pse_reg; // pseudo_stop_watchdog_enable
    logic [7:0] bypass_reg; // factory test storage
    logic [7:0] testctl_reg; // factory test storage
    logic key1_reg; // first key seen since last restart
    logic reset_request_reg;
    // counter interface
    logic restart;
    logic freeze;
    logic expire;
    logic early;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    // decoded events
    logic ctl_wr;
    logic svc_wr;
    logic rate_on;
    logic is_key;
    logic too_early;
    logic rate_start;
    logic [RATE_W-1:0] rate_next;
    logic pair_done;
    logic fault_bad;
    logic fault_early;

    wdt_axil_slave u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    wdt_period_counter #(
        .RATE_LOG2(RATE_LOG2)
    ) u_count (
        .core_clk(core_clk),
        .rst(rst),
        .rate(rate_reg),
        .restart(restart),
        .freeze(freeze),
        .expire(expire),
        .early(early),
        .count(count),
        .period(period)
    );

    // write decode
    assign ctl_wr = wr_en && (wr_idx == IDX_CONTROL);
    assign svc_wr = wr_en && (wr_idx == IDX_SERVICE);
    assign rate_on = (rate_reg != 3'h0);
    assign is_key = (wr_data == KEY_FIRST) || (wr_data == KEY_SECOND);
    assign too_early = window_reg && early;
    // user mode only gets the first write to the rate and window bits
    assign rate_next = (special_mode || !ctl_locked_reg) ?
        wr_data[RATE_W-1:0] : rate_reg;
    // a refused write to a locked rate must not restart the period
    assign rate_start = ctl_wr && (rate_next != 3'h0) &&
        (special_mode || !ctl_locked_reg);

    // service register events; all masked while disabled
    assign fault_bad = svc_wr && rate_on && !is_key;
    assign fault_early = svc_wr && rate_on && is_key &&
        too_early;
    assign pair_done = svc_wr && rate_on && !too_early &&
        key1_reg && (wr_data == KEY_SECOND);
    assign restart = pair_done || rate_start || fault_bad || fault_early;

    // debug halt and static hold in pseudo-stop
    assign freeze = (debug_halt_reg && debug_active) ||
        (pseudo_stop_active && !pse_reg);
    assign periodic_timer_freeze = debug_halt_reg && debug_active;

    // window and rate bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            window_reg <= CONTROL_RST[CTL_WINDOW_BIT];
            rate_reg <= CONTROL_RST[RATE_W-1:0];
            ctl_locked_reg <= 1'b0;
        end else if (ctl_wr) begin
            ctl_locked_reg <= 1'b1;
            rate_reg <= rate_next;
            if (special_mode || !ctl_locked_reg) begin
                window_reg <= wr_data[CTL_WINDOW_BIT];
            end
        end
    end

    // debug-halt bit, single write regardless of mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            debug_halt_reg <= CONTROL_RST[CTL_DEBUG_BIT];
            dbg_locked_reg <= 1'b0;
        end else if (ctl_wr && !dbg_locked_reg) begin
            debug_halt_reg <= wr_data[CTL_DEBUG_BIT];
            dbg_locked_reg <= 1'b1;
        end
    end

    // pseudo-stop enable, write anytime
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pse_reg <= AUX_RST[AUX_PSE_BIT];
        end else if (wr_en && wr_idx == IDX_AUX) begin
            pse_reg <= wr_data[AUX_PSE_BIT];
        end
    end

    // factory test registers only take writes in special mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bypass_reg <= BYPASS_RST;
            testctl_reg <= TESTCTL_RST;
        end else if (wr_en && special_mode) begin
            if (wr_idx == IDX_BYPASS) begin
                bypass_reg <= wr_data;
            end
            if (wr_idx == IDX_TESTCTL) begin
                testctl_reg <= wr_data;
            end
        end
    end

    // first-key tracker; repeats of either key change nothing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            key1_reg <= 1'b0;
        end else if (restart || expire || !rate_on) begin
            key1_reg <= 1'b0;
        end else if (svc_wr && wr_data == KEY_FIRST) begin
            key1_reg <= 1'b1;
        end
    end

    // one registered pulse per fault, for the reset generator
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reset_request_reg <= 1'b0;
        end else begin
            reset_request_reg <= expire || fault_bad ||
                fault_early;
        end
    end
    assign reset_request = reset_request_reg;

    // read mux; test registers hide their contents in user mode
    always_comb begin
        rd_data = 8'h00;
        case (rd_idx)
            IDX_CONTROL: begin
                rd_data = {window_reg, debug_halt_reg, 3'h0, rate_reg};
            end
            IDX_BYPASS: begin
                rd_data = special_mode ? bypass_reg : BYPASS_RST;
            end
            IDX_TESTCTL: begin
                rd_data = special_mode ? testctl_reg : TESTCTL_RST;
            end
            IDX_SERVICE: begin
                rd_data = SERVICE_READ;
            end
            IDX_AUX: begin
                rd_data = {7'h00, pse_reg};
            end
            IDX_STATUS: begin
                // live state: window open, running, first key seen
                rd_data = {5'h00, !too_early, rate_on, key1_reg};
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_rate_lock: assert property (
        ctl_wr && ctl_locked_reg && !special_mode |=>
            $stable(rate_reg) && $stable(window_reg))
        else $error("rate or window changed after lock");
    chk_debug_lock: assert property (
        ctl_wr && dbg_locked_reg |=> $stable(debug_halt_reg))
        else $error("debug-halt bit rewritten");
    chk_freeze_hold: assert property (
        debug_halt_reg && debug_active && !restart |=> $stable(count))
        else $error("counter moved while halted");
    chk_timeout_fault: assert property (
        rate_on && !freeze && !restart && count == period - 1'b1 |=>
            reset_request && count == '0)
        else $error("time-out did not request reset");
    chk_pair_restart: assert property (
        svc_wr && rate_on && key1_reg && wr_data == KEY_SECOND &&
            !too_early |=> count == '0 && !reset_request && !key1_reg)
        else $error("key pair did not restart");
    chk_bad_key: assert property (
        svc_wr && rate_on && !is_key |=> reset_request)
        else $error("bad key without reset");
    chk_repeat_ok: assert property (
        svc_wr && rate_on && is_key && !too_early && !expire |=>
            !reset_request)
        else $error("valid key caused reset");
    chk_disabled_quiet: assert property (
        svc_wr && !rate_on |=> !reset_request && $stable(count))
        else $error("service write acted while disabled");
    chk_early_window: assert property (
        svc_wr && rate_on && window_reg && early |=> reset_request)
        else $error("early window write not faulted");
    chk_rate_start: assert property (
        rate_start |=> count == '0 && rate_on)
        else $error("nonzero rate did not start period");
    chk_test_reads: assert property (
        !special_mode |-> (rd_idx == IDX_BYPASS ? rd_data == 8'h00 :
            rd_idx != IDX_TESTCTL || rd_data == TESTCTL_RST))
        else $error("test register leaked in user mode");
    chk_pulse_once: assert property (
        reset_request |=> !reset_request)
        else $error("reset request longer than one cycle");

    cov_pair: cover property (pair_done);
    cov_timeout: cover property (expire);
    cov_window_fault: cover property (fault_early);
    cov_pse_hold: cover property (pseudo_stop_active && !pse_reg && rate_on);
endmodule // wdt_watchdog

// File: bench/tb.sv
`timescale 1ns/1ps
// self-checking bench for the windowed watchdog, driven over axi4-lite
module tb;
    import wdt_pkg::*;
    // small periods: code n gives 2^(n+3) cycles
    localparam logic [34:0] SMALL_LOG2 =
        {5'hA, 5'h9, 5'h8, 5'h7, 5'h6, 5'h5, 5'h4};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF; // all lanes unless a test clears them
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [1:0] bresp_seen; // response of the last write
    logic [31:0] rdata;
    logic special_mode = 1'b0, debug_active = 1'b0, pseudo_stop_active = 1'b0;
    logic reset_request, periodic_timer_freeze;
    int fail_count = 0, checks_done = 0, rq_cnt = 0, n, base;
    int seed = 32'h9fa95421;
    logic seen;
    logic [31:0] rd, rp;
    logic [7:0] r1, bad;

    wdt_watchdog #(.RATE_LOG2(SMALL_LOG2)) u_dut (
        .core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .special_mode(special_mode), .debug_active(debug_active),
        .pseudo_stop_active(pseudo_stop_active),
        .reset_request(reset_request),
        .periodic_timer_freeze(periodic_timer_freeze)
    );

    // 50 mhz clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // pulses counted at the falling edge, where outputs are settled
    always @(negedge core_clk) begin
        if (reset_request === 1'b1) rq_cnt++;
    end

    function automatic int period_of(input int code);
        return 1 << (code + 3);
    endfunction

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_int(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // sync reset held ten cycles; clears the write locks too
    task automatic do_reset();
        @(posedge core_clk) rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        int k;
        k = 0;
        @(posedge core_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge core_clk);
            ah = awvalid && (awready === 1'b1);
            wh = wvalid && (wready === 1'b1);
            bh = (bvalid === 1'b1);
            bresp_seen = bresp;
            @(posedge core_clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            k++;
        end while (!bh && k < 50);
        bready <= 1'b0;
        if (!bh) chk_int("write response", 1, 0);
    endtask

    // read returns data and response taken at the answering edge
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [31:0] r);
        logic ah, rh;
        int k;
        k = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ah = arvalid && (arready === 1'b1);
            rh = (rvalid === 1'b1);
            d = rdata;
            r = {30'h0, rresp};
            @(posedge core_clk);
            if (ah) arvalid <= 1'b0;
            k++;
        end while (!rh && k < 50);
        rready <= 1'b0;
        if (!rh) chk_int("read response", 1, 0);
    endtask

    // counts falling edges until a reset pulse or the limit
    task automatic wait_pulse(input int lim, output int c, output logic s);
        c = 0;
        do begin
            @(negedge core_clk);
            c++;
        end while (reset_request !== 1'b1 && c < lim);
        s = (reset_request === 1'b1);
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        #600000;
        fail_count++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // reset values and unmapped access
        axi_rd(8'h20, rd, rp);
        chk_val("control", 32'h0, rd);
        chk_val("control resp", {30'h0, RESP_OKAY}, rp);
        axi_rd(8'h24, rd, rp);
        chk_val("bypass", 32'h0, rd);
        axi_rd(8'h28, rd, rp);
        chk_val("testctl", 32'h80, rd);
        axi_rd(8'h40, rd, rp);
        chk_val("unmapped resp", {30'h0, RESP_SLVERR}, rp);
        axi_wr(8'h40, 8'h00);
        chk_val("unmapped bresp", {30'h0, RESP_SLVERR},
                {30'h0, bresp_seen});
        // disabled watchdog ignores a bad service value
        base = rq_cnt;
        axi_wr(8'h2C, 8'h13);
        chk_val("service bresp", {30'h0, RESP_OKAY},
                {30'h0, bresp_seen});
        repeat (30) @(negedge core_clk);
        chk_int("disabled pulses", base, rq_cnt);
        // user mode: debug active but halt bit clear keeps counting
        @(posedge core_clk) debug_active <= 1'b1;
        axi_wr(8'h20, 8'h01);
        chk_val("freeze", 32'h0, {31'h0, periodic_timer_freeze});
        wait_pulse(40, n, seen);
        wait_pulse(40, n, seen);
        chk_int("gap code1", 16, n);
        axi_wr(8'h20, 8'h02);
        axi_rd(8'h20, rd, rp);
        chk_val("locked control", 32'h01, rd);
        @(posedge core_clk) debug_active <= 1'b0;
        // key pairs with repeats hold off the time-out
        do_reset();
        axi_wr(8'h20, 8'h03);
        base = rq_cnt;
        repeat (6) begin
            axi_wr(8'h2C, KEY_FIRST);
            axi_wr(8'h2C, KEY_FIRST);
            axi_wr(8'h2C, KEY_SECOND);
            axi_wr(8'h2C, KEY_SECOND);
        end
        chk_int("serviced pulses", base, rq_cnt);
        axi_rd(8'h2C, rd, rp);
        chk_val("service read", 32'h0, rd);
        bad = 8'($random(seed));
        if (bad == KEY_FIRST || bad == KEY_SECOND) bad = 8'h00;
        // the pulse rises with bvalid, inside the write task
        base = rq_cnt;
        axi_wr(8'h2C, bad);
        repeat (6) @(negedge core_clk);
        chk_int("bad key pulse", base + 1, rq_cnt);
        // special mode: every nonzero rate code, rewritten at will
        @(posedge core_clk) special_mode <= 1'b1;
        for (int code = 1; code < 8; code++) begin
            axi_wr(8'h20, 8'(code));
            wait_pulse(period_of(code) + 4, n, seen);
            chk_int("fresh period", 1,
                int'(n >= period_of(code) - 3 && n <= period_of(code)));
            wait_pulse(period_of(code) + 4, n, seen);
            chk_int("gap", period_of(code), n);
        end
        // test registers: writable in special only, fixed user reads
        for (int i = 0; i < 2; i++) begin
            r1 = 8'($random(seed));
            @(posedge core_clk) special_mode <= 1'b1;
            axi_wr(8'h24 + 8'(4 * i), r1);
            wstrb <= 4'h0; // lane-less write must not land
            axi_wr(8'h24 + 8'(4 * i), ~r1);
            wstrb <= 4'hF;
            axi_rd(8'h24 + 8'(4 * i), rd, rp);
            chk_val("special rw", {24'h0, r1}, rd);
            @(posedge core_clk) special_mode <= 1'b0;
            axi_wr(8'h24 + 8'(4 * i), ~r1);
            axi_rd(8'h24 + 8'(4 * i), rd, rp);
            chk_val("user read", (i == 0) ? 32'h0 : 32'h80, rd);
            @(posedge core_clk) special_mode <= 1'b1;
            axi_rd(8'h24 + 8'(4 * i), rd, rp);
            chk_val("user write refused", {24'h0, r1}, rd);
        end
        @(posedge core_clk) special_mode <= 1'b0;
        // window mode: early write faults, late pair accepted
        do_reset();
        axi_wr(8'h20, 8'h84);
        base = rq_cnt;
        axi_wr(8'h2C, KEY_FIRST);
        repeat (6) @(negedge core_clk);
        chk_int("early pulse", base + 1, rq_cnt);
        // window shut, running, first key cleared by the fault
        axi_rd(8'h34, rd, rp);
        chk_val("status early", 32'h2, rd);
        repeat (96) @(negedge core_clk);
        base = rq_cnt;
        axi_wr(8'h2C, KEY_FIRST);
        axi_wr(8'h2C, KEY_FIRST);
        axi_wr(8'h2C, KEY_SECOND);
        chk_int("window pulses", base, rq_cnt);
        axi_wr(8'h2C, KEY_FIRST);
        repeat (6) @(negedge core_clk);
        chk_int("after pair", base + 1, rq_cnt);
        // debug halt freezes the count
        do_reset();
        axi_wr(8'h20, 8'h41);
        @(posedge core_clk) debug_active <= 1'b1;
        @(negedge core_clk);
        chk_val("freeze on", 32'h1, {31'h0, periodic_timer_freeze});
        wait_pulse(40, n, seen);
        chk_val("halted", 32'h0, {31'h0, seen});
        @(posedge core_clk) debug_active <= 1'b0;
        wait_pulse(20, n, seen);
        chk_val("resumed", 32'h1, {31'h0, seen});
        // pseudo-stop holds unless its enable is set
        do_reset();
        axi_wr(8'h20, 8'h01);
        @(posedge core_clk) pseudo_stop_active <= 1'b1;
        wait_pulse(40, n, seen);
        chk_val("stop held", 32'h0, {31'h0, seen});
        axi_wr(8'h30, 8'h01);
        wait_pulse(20, n, seen);
        chk_val("stop runs", 32'h1, {31'h0, seen});
        @(posedge core_clk) pseudo_stop_active <= 1'b0;
        test_done();
    end
endmodule // tb
